// >>> rtl/psm_consts.vh
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH

// register byte offsets
`define PSM_REG_CTRL      8'h00
`define PSM_REG_IDLE      8'h04
`define PSM_REG_LAT       8'h08
`define PSM_REG_EXITLAT   8'h0C
`define PSM_REG_VID       8'h10
`define PSM_REG_STATUS    8'h14

// control fields
`define PSM_CTRL_PKG_EN   0
`define PSM_CTRL_PD_EN    1
`define PSM_CTRL_MODE_LSB 2
`define PSM_CTRL_MODE_MSB 4
`define PSM_CTRL_SR_REQ   5
`define PSM_CTRL_MDLL_EN  6
`define PSM_CTRL_MPLL_EN  7
`define PSM_CTRL_PCIE     8
`define PSM_CTRL_ASPM     9
`define PSM_CTRL_W        10

// reset values
`define PSM_CTRL_RST      10'h000
`define PSM_IDLE_RST      16'h0040
`define PSM_LAT_RST       24'hFF_FFFF
`define PSM_EXITLAT_RST   24'h20_4010
`define PSM_VID_RST       32'hA0_3040_50

// dram power-down modes
`define PSM_PD_ACTIVE     3'h0
`define PSM_PD_PRE_FAST   3'h1
`define PSM_PD_PRE_SLOW   3'h2
`define PSM_PD_REG_IBT_ON 3'h3
`define PSM_PD_REG_IBT_OFF 3'h4

// package states
`define PSM_PKG_ACTIVE    3'h0
`define PSM_PKG_SNOOP     3'h2
`define PSM_PKG_LIGHT     3'h3
`define PSM_PKG_DEEP      3'h6

// core states
`define PSM_CORE_RUN      3'h0
`define PSM_CORE_HALT     3'h1
`define PSM_CORE_HALT_LF  3'h2
`define PSM_CORE_FLUSH    3'h3
`define PSM_CORE_GATED    3'h6
`define PSM_CORE_DEEPEST  3'h7

// memory clock counts
`define PSM_PD_EXIT_CYC   5
`define PSM_SLOW_DATA_CYC 16

`endif

// >>> rtl/psm_rank_ctl.v
`timescale 1ns/1ns
`include "psm_consts.vh"

module psm_rank_ctl (
	input  wire        clk_i,
	input  wire        rstn_i,
	input  wire        busy_i,
	input  wire        pd_en_i,
	input  wire [2:0]  pd_mode_i,
	input  wire [15:0] idle_limit_i,
	input  wire        sr_req_i,
	output reg  [1:0]  cke_o,
	output reg         dll_off_o,
	output reg         ibt_off_o,
	output wire        in_pd_o,
	output wire        in_sr_o,
	output wire        cmd_ok_o,
	output reg         data_ok_o
);
	localparam [2:0] ST_ACTIVE = 3'h0;
	localparam [2:0] ST_PD     = 3'h1;
	localparam [2:0] ST_EXIT   = 3'h2;
	localparam [2:0] ST_SR     = 3'h3;
	localparam [2:0] ST_SR_EXIT = 3'h4;
	localparam [4:0] EXIT_CYC  = `PSM_PD_EXIT_CYC;
	localparam [4:0] DATA_CYC  = `PSM_SLOW_DATA_CYC;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [15:0] idle_cnt;
	reg  [4:0]  exit_cnt;
	reg  [4:0]  data_cnt;
	reg  [2:0]  pd_mode;

	assign in_pd_o  = (state == ST_PD);
	assign in_sr_o  = (state == ST_SR);
	assign cmd_ok_o = (state == ST_ACTIVE);

	always @* begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (sr_req_i)
					next_state = ST_SR;
				else if (pd_en_i && !busy_i && idle_cnt >= idle_limit_i)
					next_state = ST_PD;
			end
			ST_PD: begin
				if (sr_req_i)
					next_state = ST_SR;
				else if (busy_i || !pd_en_i)
					next_state = ST_EXIT;
			end
			ST_EXIT: begin
				if (exit_cnt == EXIT_CYC - 5'd1)
					next_state = ST_ACTIVE;
			end
			ST_SR: begin
				if (!sr_req_i)
					next_state = ST_SR_EXIT;
			end
			ST_SR_EXIT: begin
				if (exit_cnt == EXIT_CYC - 5'd1)
					next_state = ST_ACTIVE;
			end
			default: next_state = ST_ACTIVE;
		endcase
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state     <= ST_ACTIVE;
			idle_cnt  <= 16'h0000;
			exit_cnt  <= 5'h00;
			data_cnt  <= 5'h00;
			pd_mode   <= `PSM_PD_ACTIVE;
			cke_o     <= 2'h3;
			dll_off_o <= 1'b0;
			ibt_off_o <= 1'b0;
			data_ok_o <= 1'b1;
		end else begin
			state <= next_state;
			if (state != ST_ACTIVE || busy_i)
				idle_cnt <= 16'h0000;
			else if (idle_cnt != 16'hFFFF)
				idle_cnt <= idle_cnt + 16'h0001;
			if (state == ST_EXIT || state == ST_SR_EXIT)
				exit_cnt <= exit_cnt + 5'd1;
			else
				exit_cnt <= 5'h00;
			if (state == ST_ACTIVE && next_state == ST_PD)
				pd_mode <= pd_mode_i;
			case (next_state)
				ST_PD: begin
					if (pd_mode == `PSM_PD_REG_IBT_ON || pd_mode == `PSM_PD_REG_IBT_OFF ||
					    (state == ST_ACTIVE && (pd_mode_i == `PSM_PD_REG_IBT_ON ||
					    pd_mode_i == `PSM_PD_REG_IBT_OFF)))
						cke_o <= 2'h0;
					else
						cke_o <= 2'h2;
				end
				ST_SR: cke_o <= 2'h0;
				default: cke_o <= 2'h3;
			endcase
			// fast exit keeps dll, slow exit drops it
			dll_off_o <= (next_state == ST_PD) &&
			             ((state == ST_ACTIVE) ? (pd_mode_i == `PSM_PD_PRE_SLOW) : (pd_mode == `PSM_PD_PRE_SLOW));
			ibt_off_o <= (next_state == ST_PD) &&
			             ((state == ST_ACTIVE) ? (pd_mode_i == `PSM_PD_REG_IBT_OFF) : (pd_mode == `PSM_PD_REG_IBT_OFF));
			// data held off after slow exit
			if (state == ST_PD && next_state == ST_EXIT && pd_mode == `PSM_PD_PRE_SLOW) begin
				data_cnt  <= DATA_CYC - 5'd1;
				data_ok_o <= 1'b0;
			end else if (state == ST_PD || state == ST_SR) begin
				data_ok_o <= 1'b0;
				data_cnt  <= 5'h00;
			end else if (data_cnt != 5'h00) begin
				data_cnt <= data_cnt - 5'd1;
			end else begin
				data_ok_o <= (next_state == ST_ACTIVE);
			end
		end
	end
endmodule

// >>> rtl/psm_top.v
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "psm_consts.vh"

module psm_top #(
	parameter NCORE = 6,
	parameter NRANK = 4,
	parameter LLCW  = 20
) (
	input  wire               clk_i,
	input  wire               rstn_i,
	input  wire [7:0]         addr_i,
	input  wire [31:0]        wdata_i,
	input  wire               wr_i,
	input  wire               rd_i,
	output reg  [31:0]        rdata_o,
	input  wire [NCORE*3-1:0] core_state_i,
	input  wire [LLCW-1:0]    llc_ways_open_i,
	output reg  [2:0]         pkg_state_o,
	output reg  [7:0]         ring_vid_o,
	output reg                min_freq_o,
	output reg                pkg_pll_on_o,
	output reg                llc_flush_o,
	output reg                lfm_resume_o,
	output reg  [NCORE-1:0]   core_clk_stop_o,
	output reg  [NCORE-1:0]   core_pll_on_o,
	output reg  [NCORE-1:0]   core_flush_o,
	output reg  [NCORE-1:0]   core_ret_req_o,
	output reg  [NCORE-1:0]   core_ctx_flush_o,
	output reg  [NCORE-1:0]   core_pgate_o,
	output reg  [NCORE-1:0]   core_lowfreq_o,
	input  wire [NRANK-1:0]   rank_busy_i,
	output wire [NRANK*2-1:0] rank_cke_o,
	output wire [NRANK-1:0]   rank_dll_off_o,
	output wire [NRANK-1:0]   rank_ibt_off_o,
	output wire [NRANK-1:0]   rank_cmd_ok_o,
	output wire [NRANK-1:0]   rank_data_ok_o,
	output reg                io_master_delay_loop_off_o,
	output reg                mem_pll_off_o,
	input  wire               link_l1_req_i,
	output reg                link_l1_o,
	output wire               link_l1_ok_o
);
	reg  [`PSM_CTRL_W-1:0] ctrl;
	reg  [15:0]            idle_limit;
	reg  [23:0]            lat_req;
	reg  [23:0]            exit_lat;
	reg  [31:0]            vid_cfg;
	reg  [2:0]             pkg_state;
	reg  [2:0]             next_pkg_state;
	wire [NRANK-1:0]       rank_in_pd;
	wire [NRANK-1:0]       rank_in_sr;
	wire                   all_sr;
	wire [7:0]             min_lat;
	wire                   all_idle;
	wire                   any_flush;
	wire                   all_gated;
	wire                   deep_ok;
	wire                   light_ok;
	wire                   ret_pll_off;
	wire [7:0]             ret_vid;
	reg  [NCORE*7-1:0]     acts;
	integer                i;
	integer                k;

	// per-core actions: {lowfreq, ctx_flush, pgate, ret_req, flush, pll_on, clk_stop}
	function [6:0] core_actions;
		input [2:0] st;
		begin
			case (st)
				`PSM_CORE_RUN:     core_actions = 7'b000_0010;
				`PSM_CORE_HALT:    core_actions = 7'b000_0011;
				`PSM_CORE_HALT_LF: core_actions = 7'b100_0011;
				`PSM_CORE_FLUSH:   core_actions = 7'b000_1111;
				`PSM_CORE_GATED:   core_actions = 7'b011_0101;
				`PSM_CORE_DEEPEST: core_actions = 7'b011_0101;
				default:           core_actions = 7'b000_0010;
			endcase
		end
	endfunction

	function is_idle3;
		input [2:0] st;
		begin
			is_idle3 = (st == `PSM_CORE_FLUSH) || (st == `PSM_CORE_GATED) || (st == `PSM_CORE_DEEPEST);
		end
	endfunction

	function is_gated;
		input [2:0] st;
		begin
			is_gated = (st == `PSM_CORE_GATED) || (st == `PSM_CORE_DEEPEST);
		end
	endfunction

	function [7:0] min8;
		input [7:0] a;
		input [7:0] b;
		begin
			min8 = (a < b) ? a : b;
		end
	endfunction

	// core state reductions
	reg r_all_idle;
	reg r_any_flush;
	reg r_all_gated;
	always @* begin
		r_all_idle  = 1'b1;
		r_any_flush = 1'b0;
		r_all_gated = 1'b1;
		acts        = {NCORE*7{1'b0}};
		for (i = 0; i < NCORE; i = i + 1) begin
			acts[i*7 +: 7] = core_actions(core_state_i[i*3 +: 3]);
			r_all_idle  = r_all_idle & is_idle3(core_state_i[i*3 +: 3]);
			r_any_flush = r_any_flush | (core_state_i[i*3 +: 3] == `PSM_CORE_FLUSH);
			r_all_gated = r_all_gated & is_gated(core_state_i[i*3 +: 3]);
		end
	end
	assign all_idle  = r_all_idle;
	assign any_flush = r_any_flush;
	assign all_gated = r_all_gated;

	// tightest of snoop, interrupt and non-snoop response needs
	assign min_lat = min8(min8(lat_req[7:0], lat_req[15:8]), lat_req[23:16]);

	// deep limited by open ways and response times
	assign deep_ok  = all_gated && (llc_ways_open_i == {LLCW{1'b0}}) && (min_lat >= exit_lat[15:8]);
	// light needs one core in flush retention
	assign light_ok = all_idle && any_flush && (min_lat >= exit_lat[7:0]);
	// pll only dropped when relock fits the budget
	assign ret_pll_off = (min_lat >= exit_lat[23:16]);
	// deeper voltage only with relaxed snoop and interrupt needs
	assign ret_vid = (min8(lat_req[7:0], lat_req[15:8]) >= exit_lat[15:8]) ? vid_cfg[23:16] : vid_cfg[15:8];

	always @* begin
		next_pkg_state = pkg_state;
		case (pkg_state)
			`PSM_PKG_ACTIVE: begin
				// entry only with all cores idle
				if (ctrl[`PSM_CTRL_PKG_EN] && all_idle) begin
					if (deep_ok)
						next_pkg_state = `PSM_PKG_DEEP;
					else if (light_ok)
						next_pkg_state = `PSM_PKG_LIGHT;
					else
						next_pkg_state = `PSM_PKG_SNOOP;
				end
			end
			`PSM_PKG_SNOOP, `PSM_PKG_LIGHT, `PSM_PKG_DEEP: begin
				if (!all_idle || !ctrl[`PSM_CTRL_PKG_EN])
					next_pkg_state = `PSM_PKG_ACTIVE;
			end
			// any other code falls back to active
			default: next_pkg_state = `PSM_PKG_ACTIVE;
		endcase
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pkg_state    <= `PSM_PKG_ACTIVE;
			pkg_state_o  <= `PSM_PKG_ACTIVE;
			ring_vid_o   <= 8'h00;
			min_freq_o   <= 1'b0;
			pkg_pll_on_o <= 1'b1;
			llc_flush_o  <= 1'b0;
			lfm_resume_o <= 1'b0;
		end else begin
			pkg_state   <= next_pkg_state;
			pkg_state_o <= next_pkg_state;
			// no package state flushes the last-level cache
			llc_flush_o <= 1'b0;
			lfm_resume_o <= (pkg_state != `PSM_PKG_ACTIVE) && (next_pkg_state == `PSM_PKG_ACTIVE);
			case (next_pkg_state)
				`PSM_PKG_SNOOP: begin
					// minimum voltage and frequency, pll kept
					ring_vid_o   <= vid_cfg[7:0];
					min_freq_o   <= 1'b1;
					pkg_pll_on_o <= 1'b1;
				end
				`PSM_PKG_LIGHT, `PSM_PKG_DEEP: begin
					ring_vid_o   <= ret_pll_off ? ret_vid : vid_cfg[7:0];
					min_freq_o   <= 1'b1;
					pkg_pll_on_o <= !ret_pll_off;
				end
				default: begin
					ring_vid_o   <= vid_cfg[31:24];
					min_freq_o   <= (pkg_state != `PSM_PKG_ACTIVE) ? 1'b1 : 1'b0;
					pkg_pll_on_o <= 1'b1;
				end
			endcase
		end
	end

	// per-core action outputs
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			core_clk_stop_o  <= {NCORE{1'b0}};
			core_pll_on_o    <= {NCORE{1'b1}};
			core_flush_o     <= {NCORE{1'b0}};
			core_ret_req_o   <= {NCORE{1'b0}};
			core_ctx_flush_o <= {NCORE{1'b0}};
			core_pgate_o     <= {NCORE{1'b0}};
			core_lowfreq_o   <= {NCORE{1'b0}};
		end else begin
			for (k = 0; k < NCORE; k = k + 1) begin
				core_clk_stop_o[k]  <= acts[k*7];
				core_pll_on_o[k]    <= acts[k*7+1];
				core_flush_o[k]     <= acts[k*7+2];
				core_ret_req_o[k]   <= acts[k*7+3];
				core_pgate_o[k]     <= acts[k*7+4];
				core_ctx_flush_o[k] <= acts[k*7+5];
				core_lowfreq_o[k]   <= acts[k*7+6];
			end
		end
	end

	// dram ranks
	genvar g;
	generate
		for (g = 0; g < NRANK; g = g + 1) begin : g_rank
			psm_rank_ctl u_rank (
				.clk_i        (clk_i),
				.rstn_i       (rstn_i),
				.busy_i       (rank_busy_i[g]),
				.pd_en_i      (ctrl[`PSM_CTRL_PD_EN]),
				.pd_mode_i    (ctrl[`PSM_CTRL_MODE_MSB:`PSM_CTRL_MODE_LSB]),
				.idle_limit_i (idle_limit),
				.sr_req_i     (ctrl[`PSM_CTRL_SR_REQ]),
				.cke_o        (rank_cke_o[g*2 +: 2]),
				.dll_off_o    (rank_dll_off_o[g]),
				.ibt_off_o    (rank_ibt_off_o[g]),
				.in_pd_o      (rank_in_pd[g]),
				.in_sr_o      (rank_in_sr[g]),
				.cmd_ok_o     (rank_cmd_ok_o[g]),
				.data_ok_o    (rank_data_ok_o[g])
			);
		end
	endgenerate

	assign all_sr = &rank_in_sr;

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_master_delay_loop_off_o <= 1'b0;
			mem_pll_off_o <= 1'b0;
		end else begin
			io_master_delay_loop_off_o <= all_sr && ctrl[`PSM_CTRL_SR_REQ] && ctrl[`PSM_CTRL_MDLL_EN];
			mem_pll_off_o <= all_sr && ctrl[`PSM_CTRL_SR_REQ] && ctrl[`PSM_CTRL_MPLL_EN];
		end
	end

	assign link_l1_ok_o = ctrl[`PSM_CTRL_PCIE] && ctrl[`PSM_CTRL_ASPM];

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			link_l1_o <= 1'b0;
		else
			link_l1_o <= link_l1_req_i && link_l1_ok_o;
	end

	// register writes
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl       <= `PSM_CTRL_RST;
			idle_limit <= `PSM_IDLE_RST;
			lat_req    <= `PSM_LAT_RST;
			exit_lat   <= `PSM_EXITLAT_RST;
			vid_cfg    <= `PSM_VID_RST;
		end else if (wr_i) begin
			case (addr_i)
				`PSM_REG_CTRL:    ctrl       <= wdata_i[`PSM_CTRL_W-1:0];
				`PSM_REG_IDLE:    idle_limit <= wdata_i[15:0];
				`PSM_REG_LAT:     lat_req    <= wdata_i[23:0];
				`PSM_REG_EXITLAT: exit_lat   <= wdata_i[23:0];
				`PSM_REG_VID:     vid_cfg    <= wdata_i;
				default: ;
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rdata_o <= 32'h0000_0000;
		else if (rd_i) begin
			case (addr_i)
				`PSM_REG_CTRL:    rdata_o <= {{(32-`PSM_CTRL_W){1'b0}}, ctrl};
				`PSM_REG_IDLE:    rdata_o <= {16'h0000, idle_limit};
				`PSM_REG_LAT:     rdata_o <= {8'h00, lat_req};
				`PSM_REG_EXITLAT: rdata_o <= {8'h00, exit_lat};
				`PSM_REG_VID:     rdata_o <= vid_cfg;
				`PSM_REG_STATUS:  rdata_o <= {8'h00, rank_in_sr[7 < NRANK ? 7 : NRANK-1:0] & 8'hFF,
				                  rank_in_pd[7 < NRANK ? 7 : NRANK-1:0] & 8'hFF,
				                  3'h0, all_sr, link_l1_o, pkg_state_o};
				default:          rdata_o <= 32'h0000_0000;
			endcase
		end else
			rdata_o <= 32'h0000_0000;
	end
endmodule

// >>> test/psm_top_properties.sv
`timescale 1ns/1ns
module psm_top_chk #(
	parameter NCORE = 6,
	parameter NRANK = 4,
	parameter LLCW  = 20
) (
	input wire               clk_i,
	input wire               rstn_i,
	input wire               rd_i,
	input wire [31:0]        rdata_o,
	input wire [NCORE*3-1:0] core_state_i,
	input wire [LLCW-1:0]    llc_ways_open_i,
	input wire [2:0]         pkg_state_o,
	input wire               min_freq_o,
	input wire               pkg_pll_on_o,
	input wire               llc_flush_o,
	input wire               lfm_resume_o,
	input wire [NCORE-1:0]   core_clk_stop_o,
	input wire [NCORE-1:0]   core_pll_on_o,
	input wire [NCORE-1:0]   core_flush_o,
	input wire [NCORE-1:0]   core_ret_req_o,
	input wire [NCORE-1:0]   core_ctx_flush_o,
	input wire [NCORE-1:0]   core_pgate_o,
	input wire [NRANK*2-1:0] rank_cke_o,
	input wire [NRANK-1:0]   rank_cmd_ok_o,
	input wire               link_l1_req_i,
	input wire               link_l1_o,
	input wire               link_l1_ok_o
);
	reg     up;
	reg     all_gated;
	reg     any_flush;
	integer k;
	always @* begin
		all_gated = 1'b1;
		any_flush = 1'b0;
		for (k = 0; k < NCORE; k = k + 1) begin
			all_gated = all_gated & (core_state_i[3*k+2 -: 2] == 2'b11);
			any_flush = any_flush | (core_state_i[3*k +: 3] == 3'h3);
		end
	end
	// first cycle after reset has no history
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			up <= 1'b0;
		else
			up <= 1'b1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_pd_exit;
		(rank_cke_o[1:0] != 2'b11) ##1 (rank_cke_o[1:0] == 2'b11);
	endsequence
	sequence s_exit_wait;
		!rank_cmd_ok_o[0] [*3] ##[1:3] rank_cmd_ok_o[0];
	endsequence
	property p_no_pkg7;
		pkg_state_o != 3'h7;
	endproperty
	a_no_pkg7: assert property (p_no_pkg7) else $error("package state seven seen");
	property p_llc_kept;
		!llc_flush_o;
	endproperty
	a_llc_kept: assert property (p_llc_kept) else $error("llc flushed in idle");
	property p_snoop;
		pkg_state_o == 3'h2 |-> pkg_pll_on_o && min_freq_o;
	endproperty
	a_snoop: assert property (p_snoop) else $error("snoopable idle actions wrong");
	property p_deep;
		pkg_state_o == 3'h6 && $past(pkg_state_o) != 3'h6 |-> $past(all_gated) && $past(llc_ways_open_i == 0);
	endproperty
	a_deep: assert property (p_deep) else $error("deep retention entered without cause");
	property p_light;
		pkg_state_o == 3'h3 && $past(pkg_state_o) != 3'h3 |-> $past(any_flush);
	endproperty
	a_light: assert property (p_light) else $error("light retention without core three");
	property p_lfm;
		up |-> lfm_resume_o == (pkg_state_o == 3'h0 && $past(pkg_state_o) != 3'h0) && (!lfm_resume_o || min_freq_o);
	endproperty
	a_lfm: assert property (p_lfm) else $error("exit not at lowest frequency");
	property p_gate;
		up && $past(core_state_i[2:1] == 2'b11) |-> core_pgate_o[0] && core_ctx_flush_o[0] && !core_pll_on_o[0];
	endproperty
	a_gate: assert property (p_gate) else $error("gated core actions wrong");
	property p_core3;
		up && $past(core_state_i[2:0] == 3'h3) |-> core_clk_stop_o[0] && core_pll_on_o[0] && core_flush_o[0] &&
			core_ret_req_o[0] && !core_pgate_o[0];
	endproperty
	a_core3: assert property (p_core3) else $error("core three actions wrong");
	property p_cke_active;
		rank_cmd_ok_o[0] |-> rank_cke_o[1:0] == 2'b11;
	endproperty
	a_cke_active: assert property (p_cke_active) else $error("active rank without clock enable");
	property p_exit;
		s_pd_exit |-> s_exit_wait;
	endproperty
	a_exit: assert property (p_exit) else $error("power-down exit time wrong");
	property p_link;
		up |-> link_l1_o == $past(link_l1_req_i && link_l1_ok_o);
	endproperty
	a_link: assert property (p_link) else $error("link low power state wrong");
	property p_rdata;
		up && !$past(rd_i) |-> rdata_o == 32'h0000_0000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule

bind psm_top psm_top_chk #(.NCORE(NCORE), .NRANK(NRANK), .LLCW(LLCW)) i_psm_top_chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_state_i(core_state_i),
	.llc_ways_open_i(llc_ways_open_i), .pkg_state_o(pkg_state_o), .min_freq_o(min_freq_o),
	.pkg_pll_on_o(pkg_pll_on_o), .llc_flush_o(llc_flush_o), .lfm_resume_o(lfm_resume_o),
	.core_clk_stop_o(core_clk_stop_o), .core_pll_on_o(core_pll_on_o), .core_flush_o(core_flush_o),
	.core_ret_req_o(core_ret_req_o), .core_ctx_flush_o(core_ctx_flush_o), .core_pgate_o(core_pgate_o),
	.rank_cke_o(rank_cke_o), .rank_cmd_ok_o(rank_cmd_ok_o), .link_l1_req_i(link_l1_req_i),
	.link_l1_o(link_l1_o), .link_l1_ok_o(link_l1_ok_o));

// >>> test/psm_dram_model.sv
`timescale 1ns/1ns
module psm_dram_model #(
	parameter NRANK = 4
) (
	input  wire               clk_i,
	input  wire               rstn_i,
	input  wire [NRANK-1:0]   work_i,
	input  wire [NRANK*2-1:0] rank_cke_i,
	input  wire [NRANK-1:0]   rank_cmd_ok_i,
	input  wire               l1_want_i,
	output reg  [NRANK-1:0]   rank_busy_o,
	output wire               link_l1_req_o
);
	integer g;
	// work served only with cke high
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rank_busy_o <= {NRANK{1'b0}};
		else
			for (g = 0; g < NRANK; g = g + 1) begin
				if (work_i[g])
					rank_busy_o[g] <= 1'b1;
				else if (rank_cmd_ok_i[g] && rank_cke_i[2*g +: 2] == 2'b11)
					rank_busy_o[g] <= 1'b0;
			end
	end
	// link asks for low power on request
	assign link_l1_req_o = l1_want_i;
endmodule

// >>> test/psm_top_tb.sv
`timescale 1ns/1ns
`include "psm_consts.vh"
module psm_top_tb;
	reg          clk_i = 1'b0;
	reg          rstn_i = 1'b0;
	reg  [7:0]   addr_i = 8'h00;
	reg  [31:0]  wdata_i = 32'h0000_0000;
	reg          wr_i = 1'b0;
	reg          rd_i = 1'b0;
	reg  [17:0]  core_state_i = 18'h0_0000;
	reg  [19:0]  llc_ways_open_i = 20'h0_0000;
	reg  [3:0]   work = 4'h0;
	reg          l1_want = 1'b0;
	wire [3:0]   rank_busy_i;
	wire         link_l1_req_i;
	wire [31:0]  rdata_o;
	wire [2:0]   pkg_state_o;
	wire [7:0]   ring_vid_o;
	wire         min_freq_o, pkg_pll_on_o, llc_flush_o, lfm_resume_o, io_master_delay_loop_off_o, mem_pll_off_o;
	wire         link_l1_o, link_l1_ok_o;
	wire [5:0]   c_stop, c_pll, c_fl, c_ret, c_ctx, c_pg, c_lf;
	wire [7:0]   rank_cke_o;
	wire [3:0]   rank_dll_off_o, rank_ibt_off_o, rank_cmd_ok_o, rank_data_ok_o;
	integer      n_fail = 0;
	integer      checked = 0;
	integer      i, n, m, c, d;
	reg  [31:0]  v;
	reg  [7:0]   ra [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	reg  [31:0]  rv [0:6] = '{32'h0, 32'h40, 32'hFF_FFFF, 32'h20_4010, 32'hA030_4050, 32'h0, 32'h0};
	reg  [23:0]  plat [0:6] = '{24'hFF_FFFF, 24'hFF_FFFF, 24'hFF_FFFF, 24'hFF_FFFF, 24'hFF_3030, 24'hFF_3030,
		24'hFF_1818};
	reg  [17:0]  pcore [0:6] = '{{6{3'h6}}, {6{3'h3}}, {{5{3'h7}}, 3'h3}, {6{3'h6}}, {6{3'h3}}, {6{3'h7}},
		{6{3'h3}}};
	// state, voltage code, pll on
	reg  [15:0]  pexp [0:6] = '{16'h6300, 16'h3300, 16'h3300, 16'h2501, 16'h3400, 16'h2501, 16'h3501};

	always #5 clk_i = ~clk_i;

	psm_top i_psm_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .core_state_i(core_state_i), .llc_ways_open_i(llc_ways_open_i),
		.pkg_state_o(pkg_state_o), .ring_vid_o(ring_vid_o), .min_freq_o(min_freq_o), .pkg_pll_on_o(pkg_pll_on_o),
		.llc_flush_o(llc_flush_o), .lfm_resume_o(lfm_resume_o), .core_clk_stop_o(c_stop), .core_pll_on_o(c_pll),
		.core_flush_o(c_fl), .core_ret_req_o(c_ret), .core_ctx_flush_o(c_ctx), .core_pgate_o(c_pg),
		.core_lowfreq_o(c_lf), .rank_busy_i(rank_busy_i), .rank_cke_o(rank_cke_o), .rank_dll_off_o(rank_dll_off_o),
		.rank_ibt_off_o(rank_ibt_off_o), .rank_cmd_ok_o(rank_cmd_ok_o), .rank_data_ok_o(rank_data_ok_o),
		.io_master_delay_loop_off_o(io_master_delay_loop_off_o), .mem_pll_off_o(mem_pll_off_o), .link_l1_req_i(link_l1_req_i),
		.link_l1_o(link_l1_o), .link_l1_ok_o(link_l1_ok_o));

	psm_dram_model i_psm_dram_model (.clk_i(clk_i), .rstn_i(rstn_i), .work_i(work), .rank_cke_i(rank_cke_o),
		.rank_cmd_ok_i(rank_cmd_ok_o), .l1_want_i(l1_want), .rank_busy_o(rank_busy_i),
		.link_l1_req_o(link_l1_req_i));

	function [6:0] cexp(input [2:0] s);
		case (s)
			3'h0: cexp = 7'b0100000;
			3'h1: cexp = 7'b1100000;
			3'h2: cexp = 7'b1100001;
			3'h3: cexp = 7'b1111000;
			default: cexp = 7'b1010110;
		endcase
	endfunction

	task complete_run;
		begin
			if (n_fail == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				$display("wrong value %s expected %h seen %h", nm, e, g);
				n_fail = n_fail + 1;
			end
		end
	endtask

	task step(input integer lim);
		begin
			@(posedge clk_i);
			#1;
			n = n + 1;
			if (n > lim) begin
				$display("wrong value wait expected done seen timeout");
				n_fail = n_fail + 1;
				complete_run;
			end
		end
	endtask

	task wr(input [7:0] a, input [31:0] dt);
		begin
			@(posedge clk_i);
			addr_i <= a;
			wdata_i <= dt;
			wr_i <= 1'b1;
			@(posedge clk_i);
			wr_i <= 1'b0;
		end
	endtask

	task rchk(input [7:0] a, input [31:0] e);
		begin
			@(posedge clk_i);
			addr_i <= a;
			rd_i <= 1'b1;
			@(posedge clk_i);
			rd_i <= 1'b0;
			#1;
			chk("rdata", e, rdata_o);
		end
	endtask

	task ranks_up;
		begin
			wr(`PSM_REG_CTRL, 32'h0000_0000);
			n = 0;
			while (rank_cke_o !== 8'hFF)
				step(20);
		end
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("vid", 32'hA0, ring_vid_o);
		for (i = 0; i < 7; i = i + 1)
			rchk(ra[i], rv[i]);
		wr(8'h18, 32'hFFFF_FFFF);
		wr(`PSM_REG_STATUS, 32'hFFFF_FFFF);
		wr(`PSM_REG_CTRL, 32'hFFFF_FC00);
		wr(`PSM_REG_IDLE, 32'h0000_0004);
		rchk(8'h18, 32'h0);
		rchk(`PSM_REG_STATUS, 32'h0);
		rchk(`PSM_REG_CTRL, 32'h0);
		rchk(`PSM_REG_IDLE, 32'h4);
		@(posedge clk_i);
		core_state_i <= {3'h7, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
		repeat (2) @(posedge clk_i);
		#1;
		for (i = 0; i < 6; i = i + 1) begin
			v = {25'h0, c_stop[i], c_pll[i], c_fl[i], c_ret[i], c_ctx[i], c_pg[i], c_lf[i]};
			chk("core", cexp(core_state_i[3*i +: 3]), v);
		end
		@(posedge clk_i);
		core_state_i <= 18'h0_0000;
		wr(`PSM_REG_CTRL, 32'h0000_0001);
		for (i = 0; i < 7; i = i + 1) begin
			wr(`PSM_REG_LAT, {8'h00, plat[i]});
			llc_ways_open_i <= (i == 3) ? 20'h0_0001 : 20'h0_0000;
			core_state_i <= pcore[i];
			n = 0;
			while (pkg_state_o !== pexp[i][14:12])
				step(10);
			chk("vid", pexp[i][11:4], ring_vid_o);
			chk("pll", pexp[i][0], pkg_pll_on_o);
			chk("minimum_frequency", 1, min_freq_o);
			@(posedge clk_i);
			core_state_i <= 18'h0_0000;
			n = 0;
			while (pkg_state_o !== 3'h0)
				step(10);
			chk("lfm", 3, {lfm_resume_o, min_freq_o});
			step(20);
			chk("lfm", 0, lfm_resume_o);
		end
		wr(`PSM_REG_CTRL, 32'h0000_0000);
		for (m = 0; m < 5; m = m + 1) begin
			ranks_up;
			wr(`PSM_REG_CTRL, 32'h0000_0002 | (m << 2));
			n = 0;
			while (rank_cke_o[1:0] !== ((m >= 3) ? 2'b00 : 2'b10))
				step(40);
			chk("pd", {m == 2, m == 4, 1'b0}, {rank_dll_off_o[0], rank_ibt_off_o[0], rank_data_ok_o[0]});
			@(posedge clk_i);
			work <= 4'h1;
			n = 0;
			while (rank_cke_o[1:0] !== 2'b11)
				step(20);
			c = 0;
			d = 0;
			repeat (24) begin
				if (rank_cmd_ok_o[0] !== 1'b1)
					c = c + 1;
				if (rank_data_ok_o[0] !== 1'b1)
					d = d + 1;
				@(posedge clk_i);
				#1;
			end
			chk("exit", 1, c >= 3 && c <= 5);
			chk("rank1", (m >= 3) ? 2'b00 : 2'b10, rank_cke_o[3:2]);
			chk("data", 1, (m == 2) ? (d >= 15 && d <= 17) : (d <= 6));
			@(posedge clk_i);
			work <= 4'h0;
		end
		ranks_up;
		wr(`PSM_REG_CTRL, 32'h0000_00E0);
		n = 0;
		while (rank_cke_o !== 8'h00)
			step(20);
		// shutdown flags follow all-ranks-in-refresh by one clock
		step(20);
		chk("srpll", 3, {io_master_delay_loop_off_o, mem_pll_off_o});
		rchk(`PSM_REG_STATUS, 32'h000F_0010);
		wr(`PSM_REG_CTRL, 32'h0000_0020);
		repeat (2) @(posedge clk_i);
		#1;
		chk("srpll", 0, {io_master_delay_loop_off_o, mem_pll_off_o, rank_cke_o});
		ranks_up;
		wr(`PSM_REG_CTRL, 32'h0000_0300);
		l1_want <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk("link", 3, {link_l1_o, link_l1_ok_o});
		wr(`PSM_REG_CTRL, 32'h0000_0200);
		repeat (2) @(posedge clk_i);
		#1;
		chk("link", 0, {link_l1_o, link_l1_ok_o});
		complete_run;
	end
endmodule
